// File: rtl/rot_ret_pkg.sv
package rot_ret_pkg;

   // ***************************************************************
   // register map, byte addresses of aligned 32-bit words
   // ***************************************************************
   localparam logic [4:0] OFS_CMD    = 5'h00; // opcode and operand, starts
   localparam logic [4:0] OFS_STATUS = 5'h04; // busy, rejected
   localparam logic [4:0] OFS_FLAGS  = 5'h08; // flag byte
   localparam logic [4:0] OFS_PC     = 5'h0c; // program counter
   localparam logic [4:0] OFS_SP     = 5'h10; // stack pointer
   localparam logic [4:0] OFS_RP     = 5'h14; // working register group

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int CMD_OPC_LSB    = 0;  // opcode byte in command word
   localparam int CMD_OPND_LSB   = 8;  // operand byte in command word
   localparam int STAT_BUSY_BIT  = 0;  // instruction in progress
   localparam int STAT_REJ_BIT   = 1;  // sticky, write one to clear
   localparam int FLAG_C_BIT     = 7;  // carry
   localparam int FLAG_Z_BIT     = 6;  // zero
   localparam int FLAG_S_BIT     = 5;  // sign
   localparam int FLAG_V_BIT     = 4;  // overflow
   localparam int FLAG_D_BIT     = 3;  // decimal adjust, never touched
   localparam int FLAG_H_BIT     = 2;  // half carry, never touched

   // ***************************************************************
   // values after reset
   // ***************************************************************
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [15:0] PC_RST    = 16'h0000;
   localparam logic [15:0] SP_RST    = 16'h0000;
   localparam logic [7:0]  RP_RST    = 8'h00;

   // ***************************************************************
   // opcodes and timing
   // ***************************************************************
   localparam logic [7:0] OPC_RETURN     = 8'haf;
   localparam logic [7:0] OPC_ROT_L      = 8'h90; // +1 is indirect form
   localparam logic [7:0] OPC_ROT_LC     = 8'h10;
   localparam logic [7:0] OPC_ROT_R      = 8'he0;
   localparam logic [7:0] OPC_ROT_RC     = 8'hc0;
   localparam logic [3:0] WREG_NIBBLE    = 4'he;  // 1110b marks r0..r15
   localparam logic [4:0] ROT_CYCLES     = 5'd6;
   localparam logic [4:0] RET_CYCLES     = 5'd14;
   localparam logic [15:0] SP_POP_STEP   = 16'h0002;

   // rotate flavours
   typedef enum logic [1:0] {
      ROT_LEFT,
      ROT_LEFT_C,
      ROT_RIGHT,
      ROT_RIGHT_C
   } rot_kind_t;

   // sequencer states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_PTR_RD,
      ST_PTR_DATA,
      ST_OPND_RD,
      ST_OPND_DATA,
      ST_POP_HI_RD,
      ST_POP_HI_DATA,
      ST_POP_LO_RD,
      ST_POP_LO_DATA,
      ST_HOLD
   } state_t;

   // opcode with the direct/indirect bit masked off
   function automatic logic [7:0] opc_base(input logic [7:0] opc);
      opc_base = {opc[7:1], 1'b0};
   endfunction : opc_base

   // true for any of the eight rotate opcodes
   function automatic logic is_rotate(input logic [7:0] opc);
      is_rotate = (opc_base(opc) == OPC_ROT_L)  ||
                  (opc_base(opc) == OPC_ROT_LC) ||
                  (opc_base(opc) == OPC_ROT_R)  ||
                  (opc_base(opc) == OPC_ROT_RC);
   endfunction : is_rotate

   // rotate flavour of a rotate opcode
   function automatic rot_kind_t kind_of(input logic [7:0] opc);
      if (opc_base(opc) == OPC_ROT_L) begin
         kind_of = ROT_LEFT;
      end else if (opc_base(opc) == OPC_ROT_LC) begin
         kind_of = ROT_LEFT_C;
      end else if (opc_base(opc) == OPC_ROT_R) begin
         kind_of = ROT_RIGHT;
      end else begin
         kind_of = ROT_RIGHT_C;
      end
   endfunction : kind_of

endpackage : rot_ret_pkg

// File: rtl/rotate_unit.sv
`timescale 1ns/1ps
module rotate_unit (
   // operation and operand
   input  wire rot_ret_pkg::rot_kind_t kind_i,
   input  wire logic [7:0]            operand_i,
   input  wire logic                  carry_i,
   // result and new flags
   output logic [7:0]                 result_o,
   output logic                       carry_o,
   output logic                       zero_o,
   output logic                       sign_o,
   output logic                       overflow_o
);

   // ***************************************************************
   // pure datapath, no state
   // ***************************************************************
   wire is_left = (kind_i == rot_ret_pkg::ROT_LEFT) ||
                  (kind_i == rot_ret_pkg::ROT_LEFT_C);
   // bit entering at bit 0 on a left rotate
   wire left_in  = (kind_i == rot_ret_pkg::ROT_LEFT) ?
                   operand_i[7] : carry_i;
   // bit entering at bit 7 on a right rotate
   wire right_in = (kind_i == rot_ret_pkg::ROT_RIGHT) ?
                   operand_i[0] : carry_i;

   assign result_o   = is_left ? {operand_i[6:0], left_in}
                               : {right_in, operand_i[7:1]};
   // outgoing bit lands in carry
   assign carry_o    = is_left ? operand_i[7]
                               : operand_i[0];
   assign zero_o     = (result_o == 8'h00);
   assign sign_o     = result_o[7];
   // sign change across the rotation
   assign overflow_o = result_o[7] ^ operand_i[7];

endmodule : rotate_unit

// File: rtl/operand_resolver.sv
`timescale 1ns/1ps
module operand_resolver (
   // operand byte and working group
   input  wire logic [7:0] operand_i,
   input  wire logic [7:0] group_i,
   // full register file address
   output logic [7:0]      reg_addr_o
);

   // ***************************************************************
   // short working register form maps into the current group
   // ***************************************************************
   wire is_working = (operand_i[7:4] == rot_ret_pkg::WREG_NIBBLE);
   assign reg_addr_o = is_working ? {group_i[7:4], operand_i[3:0]}
                                  : operand_i;

endmodule : operand_resolver

// File: rtl/return_and_rotate_execution.sv
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module return_and_rotate_execution (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // register file port
   output logic [7:0]       rf_addr_o,
   output logic             rf_rd_o,
   input  wire logic [7:0]  rf_rdata_i,
   output logic             rf_wr_o,
   output logic [7:0]       rf_wdata_o,
   // stack memory read port
   output logic [15:0]      stk_addr_o,
   output logic             stk_rd_o,
   input  wire logic [7:0]  stk_rdata_i,
   // program counter towards fetch
   output logic [15:0]      program_counter_o,
   output logic             pc_load_o
);

   // ***************************************************************
   // byte lane merge for partial writes
   // ***************************************************************
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  be);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      lane_merge = res;
   endfunction : lane_merge

   // ***************************************************************
   // state
   // ***************************************************************
   rot_ret_pkg::state_t    state;        // sequencer
   rot_ret_pkg::rot_kind_t kind;         // latched rotate flavour
   logic [7:0]  opcode;                  // last accepted opcode
   logic [7:0]  operand;                 // last accepted operand
   logic [7:0]  flags;                   // C Z S V D H, two spare
   logic [15:0] stack_pointer;
   logic [7:0]  group;                   // working register group
   logic [7:0]  ret_hi;                  // popped high byte
   logic [4:0]  cycle_cnt;               // cycles since start
   logic [4:0]  cycle_len;               // cycles this instruction takes
   logic        rejected;                // sticky refusal flag
   logic        ack;                     // bus access in its second cycle

   // ***************************************************************
   // bus handshake: one wait state on every access
   // ***************************************************************
   wire access  = avs_read_i | avs_write_i;
   wire wr_go   = avs_write_i & ack;     // write takes effect here
   wire rd_cap  = avs_read_i & ~ack;     // read data captured here
   assign avs_waitrequest_o = access & ~ack;

   // toggles so each access sees exactly one wait cycle
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= access & ~ack;
      end
   end

   // ***************************************************************
   // address decode
   // ***************************************************************
   wire sel_cmd    = (avs_address_i == rot_ret_pkg::OFS_CMD);
   wire sel_status = (avs_address_i == rot_ret_pkg::OFS_STATUS);
   wire sel_flags  = (avs_address_i == rot_ret_pkg::OFS_FLAGS);
   wire sel_pc     = (avs_address_i == rot_ret_pkg::OFS_PC);
   wire sel_sp     = (avs_address_i == rot_ret_pkg::OFS_SP);
   wire sel_rp     = (avs_address_i == rot_ret_pkg::OFS_RP);
   wire idle       = (state == rot_ret_pkg::ST_IDLE);
   wire busy       = ~idle;

   // merged write words, only the enabled lanes change
   wire [31:0] wm_cmd = lane_merge({16'h0000, operand, opcode},
                                   avs_writedata_i, avs_byteenable_i);
   wire [31:0] wm_flg = lane_merge({24'h000000, flags},
                                   avs_writedata_i, avs_byteenable_i);
   wire [31:0] wm_pc  = lane_merge({16'h0000, program_counter_o},
                                   avs_writedata_i, avs_byteenable_i);
   wire [31:0] wm_sp  = lane_merge({16'h0000, stack_pointer},
                                   avs_writedata_i, avs_byteenable_i);
   wire [31:0] wm_rp  = lane_merge({24'h000000, group},
                                   avs_writedata_i, avs_byteenable_i);

   // command word as it would stand after the write
   wire [7:0] new_opc  = wm_cmd[rot_ret_pkg::CMD_OPC_LSB +: 8];
   wire [7:0] new_opnd = wm_cmd[rot_ret_pkg::CMD_OPND_LSB +: 8];
   wire new_is_rot = rot_ret_pkg::is_rotate(new_opc);
   wire new_is_ret = (new_opc == rot_ret_pkg::OPC_RETURN);
   wire cmd_wr     = wr_go & sel_cmd;
   // a command is only taken while idle and if it is one we execute
   wire start      = cmd_wr & idle & (new_is_rot | new_is_ret);
   wire refuse     = cmd_wr & ~start;
   // state registers are frozen while an instruction runs
   wire cfg_wr     = wr_go & idle;

   // ***************************************************************
   // read mux
   // ***************************************************************
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h00000000;                    // unmapped reads zero
      if (sel_cmd) begin
         rd_word = {16'h0000, operand, opcode};
      end else if (sel_status) begin
         rd_word[rot_ret_pkg::STAT_BUSY_BIT] = busy;
         rd_word[rot_ret_pkg::STAT_REJ_BIT]  = rejected;
      end else if (sel_flags) begin
         rd_word = {24'h000000, flags};
      end else if (sel_pc) begin
         rd_word = {16'h0000, program_counter_o};
      end else if (sel_sp) begin
         rd_word = {16'h0000, stack_pointer};
      end else if (sel_rp) begin
         rd_word = {24'h000000, group};
      end
   end

   // read data registered, stands at the edge waitrequest is low
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (rd_cap) begin
         avs_readdata_o <= rd_word;
      end
   end

   // ***************************************************************
   // refusal flag: set wins over a same-cycle clear
   // ***************************************************************
   wire rej_clr = wr_go & sel_status & avs_byteenable_i[0] &
                  avs_writedata_i[rot_ret_pkg::STAT_REJ_BIT];
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rejected <= 1'b0;
      end else if (refuse) begin
         rejected <= 1'b1;
      end else if (rej_clr) begin
         rejected <= 1'b0;
      end
   end

   // ***************************************************************
   // datapath helpers
   // ***************************************************************
   wire [7:0] direct_addr;               // operand after group mapping
   operand_resolver u_resolve (
      .operand_i  (new_opnd),
      .group_i    (group),
      .reg_addr_o (direct_addr)
   );

   wire [7:0] rot_result;
   wire       rot_c;
   wire       rot_z;
   wire       rot_s;
   wire       rot_v;
   rotate_unit u_rotate (
      .kind_i     (kind),
      .operand_i  (rf_rdata_i),
      .carry_i    (flags[rot_ret_pkg::FLAG_C_BIT]),
      .result_o   (rot_result),
      .carry_o    (rot_c),
      .zero_o     (rot_z),
      .sign_o     (rot_s),
      .overflow_o (rot_v)
   );

   // popped return address and the stack pointer past it
   wire [15:0] popped  = {ret_hi, stk_rdata_i};
   wire [15:0] sp_next = stack_pointer + rot_ret_pkg::SP_POP_STEP;
   wire        last_cycle = (cycle_cnt == cycle_len - 5'd1);

   // ***************************************************************
   // cycle counter: every instruction lasts its full cycle figure
   // ***************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || start) begin
         cycle_cnt <= 5'd0;
      end else if (busy) begin
         cycle_cnt <= cycle_cnt + 5'd1;
      end
   end

   // ***************************************************************
   // command and configuration registers
   // ***************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         opcode    <= 8'h00;
         operand   <= 8'h00;
         kind      <= rot_ret_pkg::ROT_LEFT;
         cycle_len <= rot_ret_pkg::ROT_CYCLES;
         group     <= rot_ret_pkg::RP_RST;
      end else begin
         if (start) begin
            opcode    <= new_opc;
            operand   <= new_opnd;
            kind      <= rot_ret_pkg::kind_of(new_opc);
            cycle_len <= new_is_ret ? rot_ret_pkg::RET_CYCLES
                                    : rot_ret_pkg::ROT_CYCLES;
         end
         if (cfg_wr && sel_rp) begin
            group <= wm_rp[7:0];
         end
      end
   end

   // ***************************************************************
   // sequencer: register file and stack transfers
   // ***************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state             <= rot_ret_pkg::ST_IDLE;
         rf_addr_o         <= 8'h00;
         rf_rd_o           <= 1'b0;
         rf_wr_o           <= 1'b0;
         rf_wdata_o        <= 8'h00;
         stk_addr_o        <= 16'h0000;
         stk_rd_o          <= 1'b0;
         pc_load_o         <= 1'b0;
         ret_hi            <= 8'h00;
         flags             <= rot_ret_pkg::FLAGS_RST;
         program_counter_o <= rot_ret_pkg::PC_RST;
         stack_pointer     <= rot_ret_pkg::SP_RST;
      end else begin
         // strobes are single-cycle pulses
         rf_rd_o   <= 1'b0;
         rf_wr_o   <= 1'b0;
         stk_rd_o  <= 1'b0;
         pc_load_o <= 1'b0;
         case (state)
            rot_ret_pkg::ST_IDLE: begin
               if (start && new_is_ret) begin
                  stk_addr_o <= stack_pointer;
                  stk_rd_o   <= 1'b1;
                  state      <= rot_ret_pkg::ST_POP_HI_RD;
               end else if (start) begin
                  rf_addr_o <= direct_addr;
                  rf_rd_o   <= 1'b1;
                  // odd opcode: fetch pointer first
                  state     <= new_opc[0] ? rot_ret_pkg::ST_PTR_RD
                                          : rot_ret_pkg::ST_OPND_RD;
               end else begin
                  // software owns the state registers while idle
                  if (cfg_wr && sel_flags) begin
                     flags <= wm_flg[7:0];
                  end
                  if (cfg_wr && sel_pc) begin
                     program_counter_o <= wm_pc[15:0];
                  end
                  if (cfg_wr && sel_sp) begin
                     stack_pointer <= wm_sp[15:0];
                  end
               end
            end
            rot_ret_pkg::ST_PTR_RD: begin
               state <= rot_ret_pkg::ST_PTR_DATA;
            end
            rot_ret_pkg::ST_PTR_DATA: begin
               // pointer contents are a full address, no remap
               rf_addr_o <= rf_rdata_i;
               rf_rd_o   <= 1'b1;
               state     <= rot_ret_pkg::ST_OPND_RD;
            end
            rot_ret_pkg::ST_OPND_RD: begin
               state <= rot_ret_pkg::ST_OPND_DATA;
            end
            rot_ret_pkg::ST_OPND_DATA: begin
               // write back to the same address that was read
               rf_wdata_o <= rot_result;
               rf_wr_o    <= 1'b1;
               flags[rot_ret_pkg::FLAG_C_BIT] <= rot_c;
               flags[rot_ret_pkg::FLAG_Z_BIT] <= rot_z;
               flags[rot_ret_pkg::FLAG_S_BIT] <= rot_s;
               flags[rot_ret_pkg::FLAG_V_BIT] <= rot_v;
               // D and H bits are left alone on purpose
               state <= rot_ret_pkg::ST_HOLD;
            end
            rot_ret_pkg::ST_POP_HI_RD: begin
               state <= rot_ret_pkg::ST_POP_HI_DATA;
            end
            rot_ret_pkg::ST_POP_HI_DATA: begin
               ret_hi     <= stk_rdata_i;
               stk_addr_o <= stack_pointer + 16'h0001;
               stk_rd_o   <= 1'b1;
               state      <= rot_ret_pkg::ST_POP_LO_RD;
            end
            rot_ret_pkg::ST_POP_LO_RD: begin
               state <= rot_ret_pkg::ST_POP_LO_DATA;
            end
            rot_ret_pkg::ST_POP_LO_DATA: begin
               // flags untouched on the return path
               program_counter_o <= popped;
               pc_load_o         <= 1'b1;
               stack_pointer     <= sp_next;
               state             <= rot_ret_pkg::ST_HOLD;
            end
            rot_ret_pkg::ST_HOLD: begin
               // pad out to the instruction's cycle figure
               if (last_cycle) begin
                  state <= rot_ret_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= rot_ret_pkg::ST_IDLE;
            end
         endcase
      end
   end

endmodule : return_and_rotate_execution

// File: tb/rot_ret_assertions.sv
`timescale 1ns/1ps
module rot_ret_assertions (
   // clock and reset
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   // bus handshake
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic        avs_waitrequest_o,
   // register file port
   input wire logic [7:0]  rf_addr_o,
   input wire logic        rf_rd_o,
   input wire logic [7:0]  rf_rdata_i,
   input wire logic        rf_wr_o,
   input wire logic [7:0]  rf_wdata_o,
   // stack port and program counter
   input wire logic [15:0] stk_addr_o,
   input wire logic        stk_rd_o,
   input wire logic [7:0]  stk_rdata_i,
   input wire logic [15:0] program_counter_o,
   input wire logic        pc_load_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // two stack reads two cycles apart form one pop
   sequence pop_pair; stk_rd_o ##2 stk_rd_o; endsequence
   // pointer read, then the read it points at
   sequence ptr_chain; rf_rd_o ##2 rf_rd_o; endsequence
   wait_state_a: assert property ($rose(avs_read_i | avs_write_i) |->
      avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bad wait");
   pop_addr_a: assert property (pop_pair |->
      stk_addr_o == $past(stk_addr_o, 2) + 16'h0001) else $error("pop addr");
   pop_strobes_a: assert property (pc_load_o |->
      $past(stk_rd_o, 2) && $past(stk_rd_o, 4)) else $error("pop order");
   pc_pop_a: assert property (pc_load_o |-> program_counter_o ==
      {$past(stk_rdata_i, 3), $past(stk_rdata_i)}) else $error("pc value");
   ptr_follow_a: assert property (ptr_chain |->
      rf_addr_o == $past(rf_rdata_i)) else $error("pointer unused");
   wb_after_rd_a: assert property (rf_wr_o |-> $past(rf_rd_o, 2))
      else $error("write without read");
   wb_addr_a: assert property (rf_wr_o |->
      rf_addr_o == $past(rf_addr_o, 2)) else $error("write address");
   rot_shape_a: assert property (rf_wr_o |->
      rf_wdata_o[6:1] == $past(rf_rdata_i[5:0]) ||
      rf_wdata_o[6:1] == $past(rf_rdata_i[7:2])) else $error("not rotated");
endmodule : rot_ret_assertions
bind return_and_rotate_execution rot_ret_assertions chk (.*);

// File: tb/rf_stack_model.sv
`timescale 1ns/1ps
module rf_stack_model (
   // clock
   input  wire logic        clk_i,
   // register file side
   input  wire logic [7:0]  rf_addr_i,
   input  wire logic        rf_rd_i,
   input  wire logic        rf_wr_i,
   input  wire logic [7:0]  rf_wdata_i,
   output logic [7:0]       rf_rdata_o = 8'h00,
   // stack side
   input  wire logic [15:0] stk_addr_i,
   input  wire logic        stk_rd_i,
   output logic [7:0]       stk_rdata_o = 8'h00
);
   logic [7:0] rf  [256];   // register file contents
   logic [7:0] stk [65536]; // stack data memory
   // data valid one cycle after a strobe; toggled otherwise so stale
   // values never pass for fresh ones
   always @(posedge clk_i) begin
      rf_rdata_o  <= rf_rd_i ? rf[rf_addr_i] : ~rf_rdata_o;
      stk_rdata_o <= stk_rd_i ? stk[stk_addr_i] : ~stk_rdata_o;
      if (rf_wr_i) rf[rf_addr_i] <= rf_wdata_i;
   end
endmodule : rf_stack_model

// File: tb/return_and_rotate_execution_tb.sv
`timescale 1ns/1ps
module return_and_rotate_execution_tb;
   // opcode, operand, flags in, pointer, data, result, flags out
   typedef struct {logic [7:0] opc, opnd, fin, ptr, dat, res, fout;} row_t;
   logic        sys_clk_i = 1'b0, sys_rst_i = 1'b1;
   logic        avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [4:0]  avs_address_i = 5'h00;
   logic [3:0]  avs_byteenable_i = 4'hf;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
   logic [7:0]  rf_addr_o, rf_rdata_i, rf_wdata_o, stk_rdata_i, a;
   logic        rf_rd_o, rf_wr_o, stk_rd_o, pc_load_o, avs_waitrequest_o;
   logic [15:0] stk_addr_o, program_counter_o;
   int          bad_count = 0, n_compared = 0;
   row_t rows [9] = '{
      '{8'h90,8'hc6,8'h00,8'h00,8'h88,8'h11,8'h90},
      '{8'h91,8'hc6,8'h00,8'h88,8'h44,8'h88,8'h30},
      '{8'h10,8'hc6,8'h00,8'h00,8'h8f,8'h1e,8'h90},
      '{8'h11,8'he4,8'h8c,8'hc6,8'h8f,8'h1f,8'h9c},
      '{8'he0,8'he6,8'h00,8'h00,8'h31,8'h98,8'hb0},
      '{8'he1,8'hc6,8'hff,8'h31,8'h7e,8'h3f,8'h0f},
      '{8'hc0,8'hc6,8'h00,8'h00,8'hdd,8'h6e,8'h90},
      '{8'hc1,8'h2c,8'h00,8'hed,8'h00,8'h00,8'h40},
      '{8'hc0,8'hc6,8'h80,8'h00,8'h01,8'h80,8'hb0}};
   always #4 sys_clk_i = ~sys_clk_i;
   return_and_rotate_execution uut (.*);
   rf_stack_model mdl (.clk_i(sys_clk_i), .rf_addr_i(rf_addr_o),
      .rf_rd_i(rf_rd_o), .rf_wr_i(rf_wr_o), .rf_wdata_i(rf_wdata_o),
      .rf_rdata_o(rf_rdata_i), .stk_addr_i(stk_addr_o),
      .stk_rd_i(stk_rd_o), .stk_rdata_o(stk_rdata_i));
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one bus cycle; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [4:0] ad,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      avs_address_i <= ad;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      // request stands until the edge that sees the answer
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      // read data taken at that same edge, then released
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (n >= 50) begin
         bad_count++;
         wrap_up();
      end
   endtask : bus
   // poll busy, bounded
   task automatic idle();
      int n;
      n = 0;
      do begin bus(1'b0, rot_ret_pkg::OFS_STATUS, 32'h0); n++; end
      while (q[0] !== 1'b0 && n < 20);
      if (n >= 20) begin bad_count++; wrap_up(); end
   endtask : idle
   initial begin
      repeat (6) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      bus(1'b0, rot_ret_pkg::OFS_FLAGS, 32'h0); chk(q, 32'h0);
      bus(1'b0, rot_ret_pkg::OFS_SP, 32'h0); chk(q, 32'h0);
      bus(1'b1, rot_ret_pkg::OFS_RP, 32'h70);
      foreach (rows[i]) begin
         a = rows[i].opnd[7:4] == 4'he ? {4'h7, rows[i].opnd[3:0]}
                                       : rows[i].opnd;
         if (rows[i].opc[0]) begin
            mdl.rf[a] = rows[i].ptr;
            a = rows[i].ptr;
         end
         mdl.rf[a] = rows[i].dat;
         bus(1'b1, rot_ret_pkg::OFS_FLAGS, {24'h0, rows[i].fin});
         bus(1'b1, rot_ret_pkg::OFS_CMD, {16'h0, rows[i].opnd, rows[i].opc});
         idle();
         chk({24'h0, mdl.rf[a]}, {24'h0, rows[i].res});
         bus(1'b0, rot_ret_pkg::OFS_FLAGS, 32'h0);
         chk(q, {24'h0, rows[i].fout});
      end
      mdl.stk[16'h2000] = 8'h18;
      mdl.stk[16'h2001] = 8'hb5;
      bus(1'b1, rot_ret_pkg::OFS_SP, 32'h2000);
      bus(1'b1, rot_ret_pkg::OFS_FLAGS, 32'hf3);
      bus(1'b1, rot_ret_pkg::OFS_CMD, 32'haf);
      idle();
      bus(1'b0, rot_ret_pkg::OFS_PC, 32'h0); chk(q, 32'h18b5);
      bus(1'b0, rot_ret_pkg::OFS_SP, 32'h0); chk(q, 32'h2002);
      bus(1'b0, rot_ret_pkg::OFS_FLAGS, 32'h0); chk(q, 32'hf3);
      // a second command while busy must be refused
      bus(1'b1, rot_ret_pkg::OFS_CMD, 32'hc6e0);
      bus(1'b1, rot_ret_pkg::OFS_CMD, 32'hc6e0);
      bus(1'b0, rot_ret_pkg::OFS_STATUS, 32'h0); chk({31'h0, q[1]}, 32'h1);
      idle();
      bus(1'b0, 5'h18, 32'h0); chk(q, 32'h0);
      // write one to clear, then an opcode nobody executes
      bus(1'b1, rot_ret_pkg::OFS_STATUS, 32'h2);
      bus(1'b0, rot_ret_pkg::OFS_STATUS, 32'h0); chk(q, 32'h0);
      bus(1'b1, rot_ret_pkg::OFS_CMD, 32'h00ff);
      bus(1'b0, rot_ret_pkg::OFS_STATUS, 32'h0); chk(q, 32'h2);
      // reset while idle brings PC, SP, RP and status back
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      bus(1'b0, rot_ret_pkg::OFS_PC, 32'h0); chk(q, 32'h0);
      bus(1'b0, rot_ret_pkg::OFS_SP, 32'h0); chk(q, 32'h0);
      bus(1'b0, rot_ret_pkg::OFS_RP, 32'h0); chk(q, 32'h0);
      bus(1'b0, rot_ret_pkg::OFS_STATUS, 32'h0); chk(q, 32'h0);
      // only the enabled lane of a partial write lands
      avs_byteenable_i <= 4'h2;
      bus(1'b1, rot_ret_pkg::OFS_SP, 32'h1234);
      avs_byteenable_i <= 4'hf;
      bus(1'b0, rot_ret_pkg::OFS_SP, 32'h0); chk(q, 32'h1200);
      wrap_up();
   end
endmodule : return_and_rotate_execution_tb
